// File: src/dcc_pkg.sv
// Purpose: constants for the dual comparator control block
// Assumes: wishbone classic slave, 32-bit data, one word per register
// Notes: control bit positions follow the channel register layout
package dcc_pkg;
  localparam int DCC_AW = 4;
  localparam logic [3:0] DCC_OFS_CTRL1 = 4'h0;
  localparam logic [3:0] DCC_OFS_CTRL2 = 4'h4;
  localparam logic [3:0] DCC_OFS_SHARED = 4'h8;
  localparam logic [3:0] DCC_OFS_IRQ = 4'hC;
  localparam int DCC_BIT_EN = 7;
  localparam int DCC_BIT_OUT = 6;
  localparam int DCC_BIT_OE = 5;
  localparam int DCC_BIT_POL = 4;
  localparam int DCC_BIT_SP = 3;
  localparam int DCC_BIT_REF = 2;
  localparam int DCC_BIT_CH = 0;
  localparam int DCC_BIT_MIR = 0;
  localparam int DCC_BIT_FLAG = 0;
  localparam int DCC_BIT_IE = 2;
  localparam int DCC_BIT_PERIPHERAL_IRQ_ENABLE = 4;
  localparam int DCC_BIT_GIE = 5;
  // speed bit resets to one: normal speed is the default
  localparam logic [7:0] DCC_CTRL_RST = 8'h08;
  localparam logic [1:0] DCC_FLAG_RST = 2'h0;
  localparam logic [1:0] DCC_IE_RST = 2'h0;
  localparam logic [1:0] DCC_PHASE_RST = 2'h0;
  localparam logic [1:0] DCC_PHASE_FIRST = 2'h0;
endpackage : dcc_pkg

// File: src/dcc_top.sv
// Purpose: control, output latch and change interrupt of two comparators
// Assumes: raw comparator results arrive asynchronously from analog cells
// Notes: instruction cycle is four clocks; first phase samples outputs
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module dcc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [dcc_pkg::DCC_AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [1:0] raw_result_i,
  input wire logic [1:0] pin_direction_i,
  input wire logic [1:0] port_latch_i,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o,
  output logic [1:0] pin_override_o,
  output logic [1:0] cmp_on_o,
  output logic [1:0] speed_select_o,
  output logic [1:0] reference_select_o,
  output logic [3:0] inverting_input_select_o,
  output logic irq_o,
  output logic wake_o
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] out_latch;
    logic [1:0] latch_rd;
    logic [1:0] latch_q1;
    logic [1:0] mm_prev;
    logic [1:0] flag;
    logic [1:0] irq_en;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [1:0] phase;
    logic ack;
    logic [31:0] rdata;
  } dcc_state_t;

  dcc_state_t st;
  dcc_state_t next_st;
  logic [1:0] cur_out;
  logic [1:0] mismatch;
  logic [1:0] rd_ctrl;
  logic [1:0] wr_ctrl;
  logic req;
  logic first_phase;

  assign req = cyc_i && stb_i && !st.ack;
  assign first_phase = (st.phase == DCC_PHASE_FIRST);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // polarity applies to the latched result; off channel shows polarity
      assign cur_out[g] = st.out_latch[g] ^ st.ctrl[g][DCC_BIT_POL];
      assign mismatch[g] = st.latch_rd[g] ^ st.latch_q1[g];
      assign rd_ctrl[g] = req && (adr_i == (g ? DCC_OFS_CTRL2 : DCC_OFS_CTRL1));
      assign wr_ctrl[g] = rd_ctrl[g] && we_i && sel_i[0];
      assign cmp_on_o[g] = st.ctrl[g][DCC_BIT_EN];
      assign speed_select_o[g] = st.ctrl[g][DCC_BIT_SP];
      assign reference_select_o[g] = st.ctrl[g][DCC_BIT_REF];
      assign inverting_input_select_o[2*g +: 2] =
        st.ctrl[g][DCC_BIT_CH +: 2];
      // pin path unlatched: synchronised raw value straight through
      // output enable hands the pin to the comparator, else the port latch
      assign pin_out_o[g] = st.ctrl[g][DCC_BIT_OE] ?
        ((st.sync_b[g] & st.ctrl[g][DCC_BIT_EN]) ^ st.ctrl[g][DCC_BIT_POL])
        : port_latch_i[g];
      assign pin_override_o[g] = st.ctrl[g][DCC_BIT_OE];
      assign pin_oe_o[g] = st.ctrl[g][DCC_BIT_OE] && !pin_direction_i[g]
        && st.ctrl[g][DCC_BIT_EN];
    end
  endgenerate

  // request needs all enables; wake ignores the global enable
  assign irq_o = |(st.flag & st.irq_en) && st.peripheral_irq_enable && st.global_irq_enable;
  assign wake_o = |(st.flag & st.irq_en & cmp_on_o) && st.peripheral_irq_enable;
  assign ack_o = st.ack;
  assign dat_o = st.rdata;

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.rdata = 32'h00000000;
    next_st.phase = st.phase + 2'h1;
    next_st.sync_a = raw_result_i;
    next_st.sync_b = st.sync_a;
    for (int i = 0; i < 2; i++) begin
      // raw result is high when plus input exceeds minus; gated by enable
      if (first_phase) begin
        next_st.out_latch[i] = st.sync_b[i] & st.ctrl[i][DCC_BIT_EN];
        // sample the new result so the latch tracks the output latch
        next_st.latch_q1[i] = (st.sync_b[i] & st.ctrl[i][DCC_BIT_EN])
          ^ st.ctrl[i][DCC_BIT_POL];
      end
      if (rd_ctrl[i]) begin
        next_st.latch_rd[i] = cur_out[i];
      end
      if (wr_ctrl[i]) begin
        next_st.latch_rd[i] = cur_out[i];
        next_st.ctrl[i][7] = dat_i[7];
        next_st.ctrl[i][5:0] = dat_i[5:0];
      end
      next_st.mm_prev[i] = mismatch[i];
    end
    if (req) begin
      next_st.ack = 1'b1;
      case (adr_i)
        DCC_OFS_CTRL1: next_st.rdata[7:0] = {st.ctrl[0][7], cur_out[0],
          st.ctrl[0][5:0]};
        DCC_OFS_CTRL2: next_st.rdata[7:0] = {st.ctrl[1][7], cur_out[1],
          st.ctrl[1][5:0]};
        DCC_OFS_SHARED: next_st.rdata[DCC_BIT_MIR +: 2] = cur_out;
        DCC_OFS_IRQ: next_st.rdata[7:0] = {2'h0, st.global_irq_enable, st.peripheral_irq_enable,
          st.irq_en, st.flag};
        default: next_st.rdata = 32'h00000000;
      endcase
      if (we_i && sel_i[0] && adr_i == DCC_OFS_IRQ) begin
        next_st.flag = dat_i[DCC_BIT_FLAG +: 2];
        next_st.irq_en = dat_i[DCC_BIT_IE +: 2];
        next_st.peripheral_irq_enable = dat_i[DCC_BIT_PERIPHERAL_IRQ_ENABLE];
        next_st.global_irq_enable = dat_i[DCC_BIT_GIE];
      end
    end
    // edge sets the flag; set wins over a same-cycle software clear
    for (int i = 0; i < 2; i++) begin
      if (mismatch[i] && !st.mm_prev[i]) begin
        next_st.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl[0] <= DCC_CTRL_RST;
      st.ctrl[1] <= DCC_CTRL_RST;
      st.flag <= DCC_FLAG_RST;
      st.irq_en <= DCC_IE_RST;
      st.phase <= DCC_PHASE_RST;
    end else begin
      st <= next_st;
    end
  end

  a_flag_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (mismatch[0] && !st.mm_prev[0]) |=> st.flag[0])
    else $error("flag not set on mismatch edge");
  a_irq_gating: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> (st.global_irq_enable && st.peripheral_irq_enable && |(st.irq_en & st.flag)))
    else $error("irq without all enables");
  a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_ctrl[0] && !first_phase) |=> !mismatch[0])
    else $error("control read did not clear mismatch");
  a_write_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl[1] && !first_phase) |=> !mismatch[1])
    else $error("control write did not clear mismatch");
  a_pin_oe: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_oe_o[0] |-> (cmp_on_o[0] && !pin_direction_i[0]))
    else $error("pin driven without conditions");
  a_sample_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    !first_phase |=> $stable(st.latch_q1))
    else $error("second latch moved off first phase");
  a_shared_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && adr_i == DCC_OFS_SHARED) |=> $stable(st.latch_rd))
    else $error("shared read touched latch");
  a_sync_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2))
    |-> (st.sync_b == $past(raw_result_i, 2)))
    else $error("sync path broken");
  a_reset_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (st.ctrl[0] == DCC_CTRL_RST
    && st.ctrl[1] == DCC_CTRL_RST && st.flag == DCC_FLAG_RST))
    else $error("reset state wrong");
  a_pin_source: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl[1][DCC_BIT_OE] |-> (pin_out_o[1] == port_latch_i[1]))
    else $error("port latch not on pin");
  a_flag_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(mismatch[1] && !st.mm_prev[1])
     && !(req && we_i && sel_i[0] && adr_i == DCC_OFS_IRQ))
    |=> $stable(st.flag[1]))
    else $error("flag moved without cause");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
endmodule : dcc_top

// File: verif/dcc_top_bench.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: classic wishbone master, raw results driven as plain levels
// Notes: random register fields from a fixed seed, then irq corners
`timescale 1ns/1ns
module dcc_top_bench;
  import dcc_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack, irq, wake;
  logic [3:0] adr = 0, sel = 0, iis;
  logic [31:0] wd = 0, rd, q;
  logic [1:0] raw = 0, dir = 0, plat = 0, pout, poe, pov, on, sp, rs;
  logic [7:0] d;
  logic [3:0] ra;
  int seed = 19, n_fail = 0, compares = 0, c;
  dcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd),
    .dat_o(rd), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .raw_result_i(raw), .pin_direction_i(dir),
    .port_latch_i(plat), .pin_out_o(pout), .pin_oe_o(poe),
    .pin_override_o(pov), .cmp_on_o(on), .speed_select_o(sp),
    .reference_select_o(rs), .inverting_input_select_o(iis),
    .irq_o(irq), .wake_o(wake));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= v;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic settle;
    repeat (12) @(posedge clk_i);
  endtask : settle
  task automatic sr(input logic [1:0] v);
    @(posedge clk_i);
    raw <= v;
    settle();
  endtask : sr
  function automatic logic [7:0] ec(input logic [7:0] v, input logic r);
    return {v[7], (r & v[7]) ^ v[4], v[5:0]};
  endfunction : ec
  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 2) begin
      wb(1'b0, 4'(a), 32'h0);
      chk(q, (a == 0 || a == 4) ? {24'h0, DCC_CTRL_RST} : 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = i % 2;
      ra = c ? DCC_OFS_CTRL2 : DCC_OFS_CTRL1;
      d = 8'($random(seed)) & 8'hBF;
      if (i < 2) d = 8'hBF;
      @(posedge clk_i);
      raw <= 2'($random(seed));
      dir <= 2'($random(seed));
      plat <= 2'($random(seed));
      wb(1'b1, ra, {24'h0, d});
      settle();
      wb(1'b0, ra, 32'h0);
      chk(q, {24'h0, ec(d, raw[c])});
      chk(poe[c], d[5] & ~dir[c] & d[7]);
      chk(pov[c], d[5]);
      chk(pout[c], d[5] ? ((raw[c] & d[7]) ^ d[4]) : plat[c]);
      chk({on[c], sp[c], rs[c], iis[2*c+:2]}, {d[7], d[3:0]});
      wb(1'b0, DCC_OFS_SHARED, 32'h0);
      chk(q[c], (raw[c] & d[7]) ^ d[4]);
    end
    $display("test fields done");
    @(posedge clk_i);
    raw <= 2'b00;
    wb(1'b1, DCC_OFS_CTRL2, 32'h0);
    wb(1'b1, DCC_OFS_CTRL1, 32'h80);
    settle();
    wb(1'b0, DCC_OFS_CTRL1, 32'h0);
    wb(1'b1, DCC_OFS_IRQ, 32'h1C);
    sr(2'b01);
    wb(1'b0, DCC_OFS_IRQ, 32'h0);
    chk(q, 32'h1D);
    chk(irq, 1'b0);
    chk(wake, 1'b1);
    wb(1'b1, DCC_OFS_IRQ, 32'h3C);
    chk(irq, 1'b0);
    wb(1'b0, DCC_OFS_SHARED, 32'h0);
    chk(q, 32'h1);
    sr(2'b00);
    wb(1'b0, DCC_OFS_IRQ, 32'h0);
    chk(q, 32'h3C);
    sr(2'b01);
    wb(1'b0, DCC_OFS_IRQ, 32'h0);
    chk(q, 32'h3D);
    chk(irq, 1'b1);
    wb(1'b1, DCC_OFS_CTRL1, 32'h80);
    wb(1'b1, DCC_OFS_IRQ, 32'h3C);
    sr(2'b00);
    wb(1'b0, DCC_OFS_IRQ, 32'h0);
    chk(q, 32'h3D);
    wb(1'b1, DCC_OFS_IRQ, 32'h3E);
    chk(irq, 1'b1);
    $display("test irq done");
    final_report();
  end
endmodule : dcc_top_bench
